// ===== mcsp_params.svh
/*
 Offsets, field positions, reset values and timing counts for the master
 clock select and prescaler block. Assumes inclusion by bare name.
*/
`ifndef MCSP_PARAMS_SVH
`define MCSP_PARAMS_SVH
`define MCSP_OFS_CTL 12'h000
`define MCSP_OFS_STS 12'h004
`define MCSP_OFS_BASE 12'h008
`define MCSP_OFS_APB0 12'h00C
`define MCSP_OFS_APB1 12'h010
`define MCSP_OFS_STAB 12'h014
`define MCSP_OFS_RTC 12'h018
`define MCSP_SEL_MSB 7
`define MCSP_SEL_LSB 5
`define MCSP_PLL_BIT 4
`define MCSP_SUB_BIT 3
`define MCSP_MAIN_BIT 1
`define MCSP_GATE_BIT 7
`define MCSP_BRST_BIT 4
`define MCSP_CTL_RST 8'h00
`define MCSP_BASE_RST 3'h0
`define MCSP_APB_RST 2'h0
`define MCSP_APB1_RST 8'h80
`define MCSP_STAB_RST 16'h0010
`define MCSP_SRC_HSCR 3'h0
`define MCSP_SRC_MAIN 3'h1
`define MCSP_SRC_PLL 3'h2
`define MCSP_SRC_LSCR 3'h4
`define MCSP_SRC_SUB 3'h5
`define MCSP_SWITCH_GAP 4'h4
`endif

// ===== mcsp_pkg.sv
/*
 Types for the master clock select and prescaler block.
 Assumes the params header is compiled alongside.
*/
package mcsp_pkg;
   typedef struct packed {
      logic pll;
      logic sub;
      logic main;
   } mcsp_osc_s;
   typedef enum logic [2:0] {
      SW_RUN = 3'b001,
      SW_GAP = 3'b010,
      SW_ARM = 3'b100
   } mcsp_sw_e;
   typedef struct packed {
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hsel;
   } mcsp_addr_s;
endpackage

// ===== mcsp_clock_ctrl.sv
/*
 Master clock select, oscillator enables, stable flags and the base,
 APB0 and APB1 prescalers, behind an AHB-Lite slave. Divided clocks are
 one-cycle enable pulses on mclk. Assumes a single mclk domain; the
 source request lines and stable counts are used by the clock tree.
*/
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "mcsp_params.svh"
module mcsp_clock_ctrl
   import mcsp_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic sw_rstn,
   input wire logic hs_cr_tick,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic [2:0] master_clock_current,
   output logic main_osc_run,
   output logic sub_osc_run,
   output logic pll_osc_run,
   output logic hs_cr_run,
   output logic base_clk_en,
   output logic apb0_clk_en,
   output logic apb1_bus_clock,
   output logic apb1_bus_reset
);
   mcsp_addr_s aph_ff;
   logic wr_pend_ff;
   logic rd_pend_ff;
   logic [2:0] master_clock_switch_sel_ff;
   mcsp_osc_s osc_en_ff;
   mcsp_osc_s stable_ff;
   logic [2:0] base_clock_divide_ff;
   logic [1:0] apb0_divide_ff;
   logic [1:0] apb1_divide_ff;
   logic apb1_clock_gate_ff;
   logic apb1_bus_reset_ctl_ff;
   logic [15:0] stab_count_ff;
   logic rtc_mode_enable_ff;
   logic [2:0] cur_src_ff;
   logic [2:0] pend_src_ff;
   logic [3:0] gap_cnt_ff;
   logic slow_stop_ff;
   mcsp_sw_e sw_state_ff;
   logic [3:0] base_cnt_ff;
   logic [3:0] base_ratio_ff;
   logic [2:0] apb_cnt_ff;
   logic [31:0] nxt_rdata;
   logic wr_ctl, wr_base, wr_apb0, wr_apb1, wr_stab, wr_rtc;
   logic [7:0] wb;
   logic [3:0] nxt_ratio;
   logic any_rst_n;
   logic [15:0] cnt_ff [3];
   logic [2:0] req;

   // Software reset clears only bus state, registers keep contents
   assign any_rst_n = rstn & sw_rstn;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign wb = hwdata[7:0];

   always_ff @(posedge mclk or negedge any_rst_n) begin
      if (!any_rst_n) begin
         aph_ff <= '0;
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
      end else if (hready) begin
         aph_ff <= '{haddr, htrans, hwrite, hsize, hsel};
         wr_pend_ff <= hsel & htrans[1] & hwrite;
         rd_pend_ff <= hsel & htrans[1] & ~hwrite;
      end
   end

   always_comb begin
      wr_ctl = 1'b0;
      wr_base = 1'b0;
      wr_apb0 = 1'b0;
      wr_apb1 = 1'b0;
      wr_stab = 1'b0;
      wr_rtc = 1'b0;
      if (!wr_pend_ff) begin
         wr_ctl = 1'b0;
      end else if (aph_ff.haddr[11:0] == `MCSP_OFS_CTL) begin
         wr_ctl = 1'b1;
      end else if (aph_ff.haddr[11:0] == `MCSP_OFS_BASE) begin
         wr_base = 1'b1;
      end else if (aph_ff.haddr[11:0] == `MCSP_OFS_APB0) begin
         wr_apb0 = 1'b1;
      end else if (aph_ff.haddr[11:0] == `MCSP_OFS_APB1) begin
         wr_apb1 = 1'b1;
      end else if (aph_ff.haddr[11:0] == `MCSP_OFS_STAB) begin
         wr_stab = 1'b1;
      end else if (aph_ff.haddr[11:0] == `MCSP_OFS_RTC) begin
         wr_rtc = 1'b1;
      end
   end

   // Power-on style reset only: survives software reset
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         master_clock_switch_sel_ff <= `MCSP_SRC_HSCR;
         osc_en_ff <= '0;
      end else if (wr_ctl) begin
         // Prohibited codes keep the old selection
         if (wb[`MCSP_SEL_MSB:`MCSP_SEL_LSB] != 3'h3 &&
             wb[`MCSP_SEL_MSB:`MCSP_SEL_LSB] < 3'h6) begin
            master_clock_switch_sel_ff <= wb[`MCSP_SEL_MSB:`MCSP_SEL_LSB];
         end
         osc_en_ff.pll <= wb[`MCSP_PLL_BIT];
         osc_en_ff.sub <= wb[`MCSP_SUB_BIT];
         osc_en_ff.main <= wb[`MCSP_MAIN_BIT];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         base_clock_divide_ff <= `MCSP_BASE_RST;
         apb0_divide_ff <= `MCSP_APB_RST;
         apb1_divide_ff <= `MCSP_APB_RST;
         apb1_clock_gate_ff <= 1'(`MCSP_APB1_RST >> `MCSP_GATE_BIT);
         apb1_bus_reset_ctl_ff <= 1'b0;
         stab_count_ff <= `MCSP_STAB_RST;
      end else begin
         if (wr_base && wb[2:0] != 3'h7) begin
            base_clock_divide_ff <= wb[2:0];
         end
         if (wr_apb0) begin
            apb0_divide_ff <= wb[1:0];
         end
         if (wr_apb1) begin
            apb1_divide_ff <= wb[1:0];
            apb1_clock_gate_ff <= wb[`MCSP_GATE_BIT];
            apb1_bus_reset_ctl_ff <= wb[`MCSP_BRST_BIT];
         end
         if (wr_stab) begin
            stab_count_ff <= hwdata[15:0];
         end
      end
   end

   // Ones only while sub is stable; zero always accepted
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rtc_mode_enable_ff <= 1'b0;
      end else if (wr_rtc && (!wb[0] || stable_ff.sub)) begin
         rtc_mode_enable_ff <= wb[0];
      end
   end

   // RTC mode forces sub on fast clocks halt
   assign sub_osc_run = osc_en_ff.sub | rtc_mode_enable_ff;
   assign main_osc_run = osc_en_ff.main & ~slow_stop_ff;
   assign pll_osc_run = osc_en_ff.pll & ~slow_stop_ff;
   assign hs_cr_run = ~slow_stop_ff;
   assign req = {pll_osc_run, sub_osc_run, main_osc_run};

   // Flags follow the HS CR count, not the real oscillator
   generate
      for (genvar i = 0; i < 3; i++) begin : g_stab
         always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
               cnt_ff[i] <= '0;
            end else if (!req[i]) begin
               cnt_ff[i] <= '0;
            end else if (hs_cr_tick && cnt_ff[i] != stab_count_ff) begin
               cnt_ff[i] <= cnt_ff[i] + 16'h0001;
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         stable_ff <= '0;
      end else begin
         stable_ff.main <= req[0] && cnt_ff[0] == stab_count_ff;
         stable_ff.sub <= req[1] && cnt_ff[1] == stab_count_ff;
         stable_ff.pll <= req[2] && cnt_ff[2] == stab_count_ff;
      end
   end

   // Break-before-make switch: a gap of idle cycles
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sw_state_ff <= SW_RUN;
         cur_src_ff <= `MCSP_SRC_HSCR;
         pend_src_ff <= `MCSP_SRC_HSCR;
         gap_cnt_ff <= 4'h0;
         slow_stop_ff <= 1'b0;
      end else begin
         case (sw_state_ff)
            SW_RUN: begin
               if (master_clock_switch_sel_ff != cur_src_ff) begin
                  pend_src_ff <= master_clock_switch_sel_ff;
                  gap_cnt_ff <= `MCSP_SWITCH_GAP;
                  slow_stop_ff <= 1'b0;
                  sw_state_ff <= SW_GAP;
               end
            end
            SW_GAP: begin
               if (gap_cnt_ff == 4'h0) begin
                  sw_state_ff <= SW_ARM;
               end else begin
                  gap_cnt_ff <= gap_cnt_ff - 4'h1;
               end
            end
            SW_ARM: begin
               // Status changes only once the new source drives
               cur_src_ff <= pend_src_ff;
               slow_stop_ff <= pend_src_ff == `MCSP_SRC_SUB ||
                               pend_src_ff == `MCSP_SRC_LSCR;
               sw_state_ff <= SW_RUN;
            end
            default: begin
               sw_state_ff <= SW_RUN;
            end
         endcase
      end
   end
   assign master_clock_current = cur_src_ff;

   always_comb begin
      case (base_clock_divide_ff)
         3'h0: nxt_ratio = 4'h0;
         3'h1: nxt_ratio = 4'h1;
         3'h2: nxt_ratio = 4'h2;
         3'h3: nxt_ratio = 4'h3;
         3'h4: nxt_ratio = 4'h5;
         3'h5: nxt_ratio = 4'h7;
         default: nxt_ratio = 4'hF;
      endcase
   end

   // New ratio taken only at a period boundary, no runt pulse
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         base_cnt_ff <= 4'h0;
         base_ratio_ff <= 4'h0;
         base_clk_en <= 1'b0;
      end else if (sw_state_ff != SW_RUN) begin
         base_clk_en <= 1'b0;
      end else if (base_cnt_ff >= base_ratio_ff) begin
         base_cnt_ff <= 4'h0;
         base_ratio_ff <= nxt_ratio;
         base_clk_en <= 1'b1;
      end else begin
         base_cnt_ff <= base_cnt_ff + 4'h1;
         base_clk_en <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         apb_cnt_ff <= 3'h0;
      end else if (base_clk_en) begin
         apb_cnt_ff <= apb_cnt_ff + 3'h1;
      end
   end

   // Free-running counter keeps both APB divisions glitch-free
   function automatic logic apb_tick(input logic [1:0] d,
                                     input logic [2:0] c);
      logic [2:0] m;
      m = (3'h1 << d) - 3'h1;
      apb_tick = (c & m) == m;
   endfunction

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         apb0_clk_en <= 1'b0;
         apb1_bus_clock <= 1'b0;
         apb1_bus_reset <= 1'b0;
      end else begin
         apb0_clk_en <= base_clk_en & apb_tick(apb0_divide_ff, apb_cnt_ff);
         apb1_bus_clock <= base_clk_en & apb1_clock_gate_ff &
                           apb_tick(apb1_divide_ff, apb_cnt_ff);
         apb1_bus_reset <= apb1_bus_reset_ctl_ff;
      end
   end

   // Reserved bits assemble as zero
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (aph_ff.haddr[11:0] == `MCSP_OFS_CTL) begin
         nxt_rdata[7:0] = {master_clock_switch_sel_ff, osc_en_ff.pll,
                           osc_en_ff.sub, 1'b0, osc_en_ff.main, 1'b0};
      end else if (aph_ff.haddr[11:0] == `MCSP_OFS_STS) begin
         nxt_rdata[7:0] = {cur_src_ff, stable_ff.pll, stable_ff.sub,
                           1'b0, stable_ff.main, 1'b0};
      end else if (aph_ff.haddr[11:0] == `MCSP_OFS_BASE) begin
         nxt_rdata[2:0] = base_clock_divide_ff;
      end else if (aph_ff.haddr[11:0] == `MCSP_OFS_APB0) begin
         nxt_rdata[1:0] = apb0_divide_ff;
      end else if (aph_ff.haddr[11:0] == `MCSP_OFS_APB1) begin
         nxt_rdata[7:0] = {apb1_clock_gate_ff, 2'h0, apb1_bus_reset_ctl_ff,
                           2'h0, apb1_divide_ff};
      end else if (aph_ff.haddr[11:0] == `MCSP_OFS_STAB) begin
         nxt_rdata[15:0] = stab_count_ff;
      end else if (aph_ff.haddr[11:0] == `MCSP_OFS_RTC) begin
         nxt_rdata[0] = rtc_mode_enable_ff;
      end
   end

   // Read data comes combinationally in the zero-wait data phase
   assign hrdata = rd_pend_ff ? nxt_rdata : 32'h0000_0000;

endmodule
`default_nettype wire

// ===== mcsp_clock_ctrl_asserts.sv
/*
 Port checker for mcsp_clock_ctrl, bound from the testbench top.
 Assumes one mclk domain and a zero-wait AHB-Lite data phase.
*/
`timescale 1ns/10ps
`default_nettype none
`include "mcsp_params.svh"
module mcsp_clock_ctrl_asserts (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic [2:0] master_clock_current,
   input wire logic main_osc_run,
   input wire logic sub_osc_run,
   input wire logic pll_osc_run,
   input wire logic apb1_bus_clock,
   input wire logic apb1_bus_reset
);
   logic w_q;
   logic r_q;
   logic [11:0] a_q;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         w_q <= 1'b0;
         r_q <= 1'b0;
         a_q <= 12'h000;
      end else begin
         w_q <= hsel & htrans[1] & hready & hwrite;
         r_q <= hsel & htrans[1] & hready & ~hwrite;
         a_q <= haddr[11:0];
      end
   end
   function automatic logic [7:0] resv(input logic [11:0] a);
      case (a)
         `MCSP_OFS_CTL, `MCSP_OFS_STS: resv = 8'h05;
         `MCSP_OFS_BASE: resv = 8'hF8;
         `MCSP_OFS_APB0: resv = 8'hFC;
         `MCSP_OFS_APB1: resv = 8'h6C;
         default: resv = 8'h00;
      endcase
   endfunction
   wire logic wc = w_q && (a_q == `MCSP_OFS_CTL);
   wire logic wa1 = w_q && (a_q == `MCSP_OFS_APB1);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   AST_MAIN_RUN: assert property (
      wc && hwdata[1] && hwdata[7:5] == 3'h0 &&
      master_clock_current == 3'h0 |=> main_osc_run) else $error("main run");
   AST_PLL_RUN: assert property (
      wc && hwdata[4] && hwdata[7:5] == 3'h0 &&
      master_clock_current == 3'h0 |=> pll_osc_run) else $error("pll run");
   AST_SUB_RUN: assert property (
      wc && hwdata[3] |=> sub_osc_run) else $error("sub run");
   AST_GATE: assert property (
      wa1 && !hwdata[7] |-> ##2 !apb1_bus_clock) else $error("apb1 gate");
   // Bus reset output is one register behind the control bit
   AST_BUS_RST: assert property (
      wa1 |-> ##2 apb1_bus_reset == $past(hwdata[4], 2))
      else $error("apb1 bus reset");
   AST_RESV_ZERO: assert property (
      r_q |-> hrdata[31:8] == 24'h0 && (hrdata[7:0] & resv(a_q)) == 8'h00)
      else $error("reserved bits");
   AST_STS_CUR: assert property (
      r_q && a_q == `MCSP_OFS_STS |-> hrdata[7:5] == master_clock_current)
      else $error("status select");
   AST_CUR_LEGAL: assert property (
      master_clock_current inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5})
      else $error("illegal source");
   cover property (wc && hwdata[7:5] == 3'h1);
   cover property (wa1 && !hwdata[7]);
   cover property (master_clock_current == 3'h5);
endmodule
`default_nettype wire

// ===== mcsp_clock_ctrl_test.sv
/*
 Self-checking testbench: AHB-Lite master tasks, one task per scenario.
 Assumes a zero-wait slave; the HS CR tick is made here while it runs.
*/
`timescale 1ns/10ps
`default_nettype none
`include "mcsp_params.svh"
module mcsp_clock_ctrl_test;
   logic mclk = 1'b0, rstn = 1'b0, sw_rstn = 1'b1, tick = 1'b0;
   logic hsel = 1'b0, hwrite = 1'b0, rdy_q;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd_q, q;
   logic [1:0] htrans = 2'h0;
   wire logic [31:0] hrdata;
   wire logic [2:0] cur;
   wire logic hreadyout, hresp, main_r, sub_r, pll_r, hs_r, b_en, a0_en;
   wire logic a1_clk, a1_rst;
   int err_count = 0, compares = 0;
   int div[7] = '{1, 2, 3, 4, 6, 8, 16};
   logic [2:0] codes[5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h0};
   mcsp_clock_ctrl mcsp_clock_ctrl_inst (.mclk(mclk), .rstn(rstn),
      .sw_rstn(sw_rstn), .hs_cr_tick(tick), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .master_clock_current(cur), .main_osc_run(main_r),
      .sub_osc_run(sub_r), .pll_osc_run(pll_r), .hs_cr_run(hs_r),
      .base_clk_en(b_en), .apb0_clk_en(a0_en), .apb1_bus_clock(a1_clk),
      .apb1_bus_reset(a1_rst));
   initial begin
      forever #50 mclk = ~mclk;
   end
   // Tick stops with the HS CR itself, as in slow modes
   always @(posedge mclk) begin
      rd_q <= hrdata;
      rdy_q <= hreadyout;
      tick <= hs_r & ~tick;
   end
   task automatic end_of_test();
      $display("mismatches %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic edge1();
      @(posedge mclk);
      #1;
   endtask
   task automatic bound(input int n);
      if (n >= 40) begin
         chk("wait bound", 32'h0, 32'h1);
         end_of_test();
      end
   endtask
   task automatic waitrdy();
      int n;
      n = 0;
      do begin
         edge1();
         n++;
      end while (rdy_q !== 1'b1 && n < 40);
      bound(n);
   endtask
   task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      waitrdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      waitrdy();
      q = rd_q;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rc(input string n, input logic [11:0] a, input logic [7:0] e);
      bus(1'b0, a, 32'h0);
      chk(n, {24'h0, e}, q);
   endtask
   task automatic wait_cur(input logic [2:0] e);
      int n;
      n = 0;
      while (cur !== e && n < 40) begin
         edge1();
         n++;
      end
      bound(n);
   endtask
   function automatic logic pulse(input int k);
      return (k == 0) ? b_en : (k == 1) ? a0_en : a1_clk;
   endfunction
   // First interval after a ratio change may be short, so use the second
   task automatic period(input int k, input int e);
      int n;
      n = 0;
      while (pulse(k) !== 1'b1 && n < 40) begin
         edge1();
         n++;
      end
      repeat (2) begin
         n = 0;
         do begin
            edge1();
            n++;
         end while (pulse(k) !== 1'b1 && n < 40);
      end
      chk("period", e, n);
   endtask
   task automatic t_reset();
      rc("ctl", `MCSP_OFS_CTL, 8'h00);
      rc("sts", `MCSP_OFS_STS, 8'h00);
      rc("base", `MCSP_OFS_BASE, 8'h00);
      rc("apb0", `MCSP_OFS_APB0, 8'h00);
      rc("apb1", `MCSP_OFS_APB1, 8'h80);
      rc("unmapped", 12'h100, 8'h00);
      chk("hresp", 32'h0, 32'(hresp));
      wr(`MCSP_OFS_RTC, 32'h1);
      rc("rtc refused", `MCSP_OFS_RTC, 8'h00);
   endtask
   task automatic t_enable();
      int n;
      wr(`MCSP_OFS_CTL, 32'h1F);
      rc("ctl resv", `MCSP_OFS_CTL, 8'h1A);
      rc("sts waiting", `MCSP_OFS_STS, 8'h00);
      n = 0;
      do begin
         bus(1'b0, `MCSP_OFS_STS, 32'h0);
         n++;
      end while (q !== 32'h1A && n < 39);
      chk("sts stable", 32'h1A, q);
      chk("runs", 32'h7, {29'h0, pll_r, sub_r, main_r});
      wr(`MCSP_OFS_RTC, 32'h1);
      rc("rtc taken", `MCSP_OFS_RTC, 8'h01);
      wr(`MCSP_OFS_CTL, 32'h12);
      chk("rtc keeps sub", 32'h1, 32'(sub_r));
      wr(`MCSP_OFS_RTC, 32'h0);
      chk("sub off", 32'h0, 32'(sub_r));
      wr(`MCSP_OFS_CTL, 32'h1A);
   endtask
   task automatic t_switch();
      foreach (codes[i]) begin
         wr(`MCSP_OFS_CTL, {24'h0, codes[i], 5'h1A});
         wait_cur(codes[i]);
         bus(1'b0, `MCSP_OFS_STS, 32'h0);
         chk("sts select", codes[i], q[7:5]);
         chk("main run", 32'(codes[i] < 3'h4), 32'(main_r));
         chk("pll run", 32'(codes[i] < 3'h4), 32'(pll_r));
         chk("hs run", 32'(codes[i] < 3'h4), 32'(hs_r));
      end
      for (int c = 3; c < 8; c++) begin
         if (c == 3 || c > 5) begin
            wr(`MCSP_OFS_CTL, {24'h0, 3'(c), 5'h1A});
            rc("ctl kept", `MCSP_OFS_CTL, 8'h1A);
         end
      end
      repeat (10) edge1();
      chk("current kept", 32'h0, 32'(cur));
   endtask
   task automatic t_div();
      for (int i = 0; i < 7; i++) begin
         wr(`MCSP_OFS_BASE, 32'(i));
         period(0, div[i]);
      end
      wr(`MCSP_OFS_BASE, 32'h7);
      rc("base kept", `MCSP_OFS_BASE, 8'h06);
      wr(`MCSP_OFS_BASE, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wr(`MCSP_OFS_APB0, 32'(i));
         wr(`MCSP_OFS_APB1, 32'h80 | 32'(i));
         period(1, 1 << i);
         period(2, 1 << i);
      end
   endtask
   task automatic t_apb1();
      int n;
      wr(`MCSP_OFS_APB1, 32'h00);
      n = 0;
      repeat (20) begin
         edge1();
         n += a1_clk;
      end
      chk("gated", 32'h0, n);
      wr(`MCSP_OFS_APB1, 32'hEF);
      rc("apb1 resv", `MCSP_OFS_APB1, 8'h83);
      wr(`MCSP_OFS_APB1, 32'h90);
      // Output register lags the control bit by one cycle
      edge1();
      chk("bus reset", 32'h1, 32'(a1_rst));
      wr(`MCSP_OFS_BASE, 32'h3);
      wr(`MCSP_OFS_APB0, 32'h2);
      sw_rstn <= 1'b0;
      repeat (2) edge1();
      sw_rstn <= 1'b1;
      edge1();
      rc("base kept", `MCSP_OFS_BASE, 8'h03);
      rc("apb0 kept", `MCSP_OFS_APB0, 8'h02);
      rc("apb1 kept", `MCSP_OFS_APB1, 8'h90);
      rc("ctl kept", `MCSP_OFS_CTL, 8'h1A);
      rstn <= 1'b0;
      edge1();
      rstn <= 1'b1;
      edge1();
      rc("apb1 reset", `MCSP_OFS_APB1, 8'h80);
      chk("bus reset off", 32'h0, 32'(a1_rst));
   endtask
   initial begin
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      edge1();
      t_reset();
      t_enable();
      t_switch();
      t_div();
      t_apb1();
      end_of_test();
   end
endmodule
bind mcsp_clock_ctrl mcsp_clock_ctrl_asserts mcsp_clock_ctrl_asserts_inst (
   .mclk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
   .master_clock_current, .main_osc_run, .sub_osc_run, .pll_osc_run,
   .apb1_bus_clock, .apb1_bus_reset);
`default_nettype wire
